// ---- logic/rcgp_pkg.sv ----
package rcgp_pkg;

   // Function select values on address bits 4..1
   localparam logic [3:0] RCGP_FN_GP1 = 4'h8;
   localparam logic [3:0] RCGP_FN_GP2 = 4'hA;

   // Access size codes; byte accesses are not supported
   localparam logic [1:0] RCGP_SZ_8 = 2'h0;
   localparam logic [1:0] RCGP_SZ_16 = 2'h1;
   localparam logic [1:0] RCGP_SZ_32 = 2'h2;
   localparam logic [1:0] RCGP_SZ_64 = 2'h3;

   // Register data sits in the upper half of the 32-bit word
   localparam int RCGP_DATA_LSB = 16;

   // First register bit positions
   localparam int RCGP_B1_NMI = 15;
   localparam int RCGP_B1_LINEMIS = 14;
   localparam int RCGP_B1_DBG = 13;
   localparam int RCGP_B1_SEN = 12;
   localparam int RCGP_B1_LBUS = 11;
   localparam int RCGP_B1_SYSR = 10;
   localparam int RCGP_B1_BUSR = 9;
   localparam int RCGP_B1_WARM = 8;
   localparam int RCGP_B1_LEGACY = 5;
   localparam int RCGP_B1_OVREN = 0;

   // Second register bit positions
   localparam int RCGP_B2_NPROC = 14;
   localparam int RCGP_B2_NMEM = 12;
   localparam int RCGP_B2_REV = 9;
   localparam int RCGP_B2_POLLO = 7;
   localparam int RCGP_B2_IOP = 6;
   localparam int RCGP_B2_BLS = 5;
   localparam int RCGP_B2_BECC = 4;
   localparam int RCGP_B2_CLK = 3;
   localparam int RCGP_B2_POLLI = 2;
   localparam int RCGP_B2_FLOWO = 1;
   localparam int RCGP_B2_FLOWI = 0;

   // Reset values: override field 7..0 with divisor 001 and override off
   localparam logic [7:0] RCGP_OVR_RST = 8'h20;
   localparam logic RCGP_SEN_RST = 1'b0;
   localparam logic RCGP_LBUS_RST = 1'b0;
   localparam logic RCGP_FLOW_RST = 1'b0;

   // Width of the pin status bundle
   localparam int RCGP_PINS_W = 16;

   // One local bus request, valid while sel and rd or wr are high
   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [1:0] size;
      logic [3:0] func;
      logic [31:0] wdata;
   } rcgp_lbreq_type;

   // Status levels arriving from pins and other cards
   typedef struct packed {
      logic serial_pend;
      logic kbd;
      logic proc_line128;
      logic proc_ecc;
      logic soft_cause;
      logic [1:0] nproc_m1;
      logic [1:0] nmem;
      logic poll_out;
      logic io_present;
      logic bus_line_size;
      logic bus_ecc;
      logic clk_sel;
      logic poll_in;
      logic flow_in;
   } rcgp_pins_type;

   // One-cycle request pulses towards the reset logic
   typedef struct packed {
      logic nmi;
      logic sys_rst;
      logic bus_rst;
      logic warm_rst;
   } rcgp_reqs_type;

   // Boot configuration override values
   typedef struct packed {
      logic [2:0] clk_div;
      logic sc_read_msb;
      logic sc_write_msb;
      logic parity_sel;
      logic line128;
      logic enable;
   } rcgp_ovr_type;

endpackage

// ---- logic/rcgp_sync2.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser for a bundle of unrelated levels
module rcgp_sync2
#(
   parameter int WIDTH = 1
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_reg; // Second stage, safe to use
   logic [WIDTH-1:0] q_next;

   // Next values simply shift the chain
   always_comb
   begin
      meta_next = d_i;
      q_next = meta_reg;
   end

   // Chain registers, cleared by reset
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         q_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;

endmodule

// ---- logic/rcgp_regs.sv ----
`timescale 1ns/1ps

// What this block does
// - bit13 reads serial pending, write raises debug int
// - bit12 enables serial port interrupts
// - bit11 enables processor local bus access
// - bits10,9,8 request system, bus, warm reset
// - bit8 reads last soft reset cause
// - bits7..5 clock divisor override, default 001
// - write bit0 clear, bit5 set raises debug int
// - bits4,3 cache read/write time MSBs
// - bit2 selects ECC or parity
// - bit1 selects 64 or 128 byte lines
// - bit0 enables boot configuration override
// - keyboard input also raises debug interrupt
// - second register reports processor and memory counts
// - second register reads both poll request lines
// - second register bit3 reports clock selection
// - bit1 flow-out read/write, bit0 flow-in
// - 16/32/64-bit access, data in upper half
// - function select 1000 and 1010 map registers
// - drive interrupt on serial, mismatch, debug events
// - bit15 reads line size, write requests NMI
module rcgp_regs
import rcgp_pkg::*;
#(
   parameter logic [2:0] REVISION = 3'h1 // Arbitrary revision code
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire rcgp_lbreq_type lb_req_i,
   input wire rcgp_pins_type pins_i,
   output logic [31:0] lb_rdata_o,
   output logic lb_ack_o,
   output rcgp_reqs_type reqs_o,
   output rcgp_ovr_type ovr_o,
   output logic serial_int_en_o,
   output logic local_bus_iface_en_o,
   output logic flow_out_o,
   output logic hw_int17_o
);

   // Synchronised copy of the status pins
   rcgp_pins_type pins_s;
   logic [RCGP_PINS_W-1:0] pins_raw; // Flat view for the synchroniser
   logic [RCGP_PINS_W-1:0] pins_q; // Flat synchronised view

   // Decoded request terms
   logic acc_ok; // Supported access width
   logic wr_gp1; // Write taken for the first register
   logic wr_gp2; // Write taken for the second register
   logic rd_gp1; // Read taken for the first register
   logic rd_any; // Any selected read or write this cycle, mapped or not
   logic [15:0] wd; // Write data from the upper half

   // Stored control state
   logic [7:0] ovr_reg; // Override values, bit 0 is the enable
   logic [7:0] ovr_next;
   logic sen_reg; // Serial interrupt enable
   logic sen_next;
   logic lbus_reg; // Local bus access enable
   logic lbus_next;
   logic flow_reg; // Outgoing flow control
   logic flow_next;
   logic dbg_reg; // Sticky debug-host interrupt
   logic dbg_next;
   logic kbd_reg; // Last keyboard level, for edge detect
   logic kbd_next;

   // Answer and output flops
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;
   logic ack_next;
   rcgp_reqs_type reqs_reg;
   rcgp_reqs_type reqs_next;
   logic irq_reg;
   logic irq_next;

   // Read images of the two registers
   logic [15:0] img1;
   logic [15:0] img2;
   logic line_mis; // Bus line size differs from processor
   logic ecc_mis; // Bus ECC setting differs from processor

   // True when a write or read is to the given function
   function automatic logic hit(input rcgp_lbreq_type r, input logic [3:0] fn);
      hit = r.sel && (r.func == fn);
   endfunction

   // Status pins come from other domains, so they pass two flops first
   assign pins_raw = pins_i;
   assign pins_s = rcgp_pins_type'(pins_q);

   rcgp_sync2 #(
      .WIDTH(RCGP_PINS_W)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i(pins_raw),
      .q_o(pins_q)
   );

   // Address and width decode; byte accesses neither read nor write but are still answered
   always_comb
   begin
      acc_ok = lb_req_i.size != RCGP_SZ_8;
      wd = lb_req_i.wdata[RCGP_DATA_LSB +: 16];
      wr_gp1 = lb_req_i.wr && acc_ok && hit(lb_req_i, RCGP_FN_GP1);
      wr_gp2 = lb_req_i.wr && acc_ok && hit(lb_req_i, RCGP_FN_GP2);
      rd_gp1 = lb_req_i.rd && acc_ok && hit(lb_req_i, RCGP_FN_GP1);
      rd_any = lb_req_i.sel && (lb_req_i.rd || lb_req_i.wr);
   end

   // Mismatch checks compare the processor view with the bus view
   always_comb
   begin
      line_mis = pins_s.bus_line_size != pins_s.proc_line128;
      ecc_mis = pins_s.proc_ecc != pins_s.bus_ecc;
   end

   // Read image of the first register
   always_comb
   begin
      img1 = 16'h0000;
      img1[RCGP_B1_NMI] = pins_s.proc_line128;
      img1[RCGP_B1_LINEMIS] = line_mis;
      img1[RCGP_B1_DBG] = pins_s.serial_pend;
      img1[RCGP_B1_SEN] = sen_reg;
      img1[RCGP_B1_LBUS] = lbus_reg;
      img1[RCGP_B1_SYSR] = pins_s.proc_ecc;
      img1[RCGP_B1_BUSR] = ecc_mis;
      img1[RCGP_B1_WARM] = pins_s.soft_cause;
      img1[7:0] = ovr_reg;
   end

   // Read image of the second register; bit 8 has no function
   always_comb
   begin
      img2 = 16'h0000;
      img2[RCGP_B2_NPROC +: 2] = pins_s.nproc_m1;
      img2[RCGP_B2_NMEM +: 2] = pins_s.nmem;
      img2[RCGP_B2_REV +: 3] = REVISION;
      img2[RCGP_B2_POLLO] = pins_s.poll_out;
      img2[RCGP_B2_IOP] = pins_s.io_present;
      img2[RCGP_B2_BLS] = pins_s.bus_line_size;
      img2[RCGP_B2_BECC] = pins_s.bus_ecc;
      img2[RCGP_B2_CLK] = pins_s.clk_sel;
      img2[RCGP_B2_POLLI] = pins_s.poll_in;
      img2[RCGP_B2_FLOWO] = flow_reg;
      img2[RCGP_B2_FLOWI] = pins_s.flow_in;
   end

   // Control state; writes touch only the writable fields
   always_comb
   begin
      ovr_next = ovr_reg;
      sen_next = sen_reg;
      lbus_next = lbus_reg;
      flow_next = flow_reg;
      if (wr_gp1)
      begin
         ovr_next = wd[7:0];
         sen_next = wd[RCGP_B1_SEN];
         lbus_next = wd[RCGP_B1_LBUS];
      end
      if (wr_gp2)
      begin
         flow_next = wd[RCGP_B2_FLOWO];
      end
   end

   // Debug-host flag: a new event wins over the clearing read
   always_comb
   begin
      kbd_next = pins_s.kbd;
      dbg_next = dbg_reg;
      if (rd_gp1)
      begin
         dbg_next = 1'b0;
      end
      if (wr_gp1 && wd[RCGP_B1_DBG])
      begin
         dbg_next = 1'b1;
      end
      if (wr_gp1 && !wd[RCGP_B1_OVREN] && wd[RCGP_B1_LEGACY])
      begin
         dbg_next = 1'b1;
      end
      if (pins_s.kbd && !kbd_reg)
      begin
         dbg_next = 1'b1;
      end
   end

   // Request pulses last exactly one cycle after the write
   always_comb
   begin
      reqs_next.nmi = wr_gp1 && wd[RCGP_B1_NMI];
      reqs_next.sys_rst = wr_gp1 && wd[RCGP_B1_SYSR];
      reqs_next.bus_rst = wr_gp1 && wd[RCGP_B1_BUSR];
      reqs_next.warm_rst = wr_gp1 && wd[RCGP_B1_WARM];
   end

   // Interrupt line; serial interrupts only count while enabled
   always_comb
   begin
      irq_next = (pins_s.serial_pend && sen_reg) || line_mis || ecc_mis || dbg_reg;
   end

   // Answer: one cycle after any selected access; undefined functions read zero
   always_comb
   begin
      ack_next = rd_any;
      rdata_next = 32'h0000_0000;
      if (lb_req_i.rd && acc_ok && hit(lb_req_i, RCGP_FN_GP1))
      begin
         rdata_next[RCGP_DATA_LSB +: 16] = img1;
      end
      else if (lb_req_i.rd && acc_ok && hit(lb_req_i, RCGP_FN_GP2))
      begin
         rdata_next[RCGP_DATA_LSB +: 16] = img2;
      end
   end

   // All state registers
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         ovr_reg <= RCGP_OVR_RST;
         sen_reg <= RCGP_SEN_RST;
         lbus_reg <= RCGP_LBUS_RST;
         flow_reg <= RCGP_FLOW_RST;
         dbg_reg <= 1'b0;
         kbd_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         reqs_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ovr_reg <= ovr_next;
         sen_reg <= sen_next;
         lbus_reg <= lbus_next;
         flow_reg <= flow_next;
         dbg_reg <= dbg_next;
         kbd_reg <= kbd_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         reqs_reg <= reqs_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs come straight from flops
   assign lb_rdata_o = rdata_reg;
   assign lb_ack_o = ack_reg;
   assign reqs_o = reqs_reg;
   assign ovr_o = rcgp_ovr_type'(ovr_reg);
   assign serial_int_en_o = sen_reg;
   assign local_bus_iface_en_o = lbus_reg;
   assign flow_out_o = flow_reg;
   assign hw_int17_o = irq_reg;

   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // NMI pulse follows the write for exactly one cycle
   // The second cycle may only stay high for a fresh nmi write one cycle earlier
   a_nmi_pulse: assert property (wr_gp1 && wd[RCGP_B1_NMI] |=> reqs_o.nmi ##1
      (!reqs_o.nmi || $past(wr_gp1 && wd[RCGP_B1_NMI])))
      else $error("nmi request pulse wrong");

   // Each reset request maps to its own bit
   a_reset_reqs: assert property (wr_gp1 |=> reqs_o.sys_rst == $past(wd[RCGP_B1_SYSR])
      && reqs_o.bus_rst == $past(wd[RCGP_B1_BUSR]) && reqs_o.warm_rst == $past(wd[RCGP_B1_WARM]))
      else $error("reset request bits wrong");

   // Byte writes and unmapped writes leave the override untouched
   a_ovr_guard: assert property (!wr_gp1 |=> $stable(ovr_o))
      else $error("override changed without write");

   // Legacy write sets the debug flag
   a_legacy_dbg: assert property (wr_gp1 && !wd[RCGP_B1_OVREN] && wd[RCGP_B1_LEGACY] |=> dbg_reg)
      else $error("legacy debug interrupt lost");

   // Debug flag reaches the interrupt line one cycle later
   a_dbg_irq: assert property (dbg_reg |=> hw_int17_o)
      else $error("debug flag missing from interrupt");

   // Masked serial interrupt alone keeps the line low
   a_serial_mask: assert property (!sen_reg && !dbg_reg && !line_mis && !ecc_mis |=> !hw_int17_o)
      else $error("masked serial interrupt leaked");

   // Every access answers one cycle later, lower half zero
   a_ack_timing: assert property (rd_any |=> lb_ack_o && lb_rdata_o[15:0] == 16'h0000)
      else $error("access answer timing wrong");

   // Flow-out bit follows a write to the second register
   a_flow_write: assert property (wr_gp2 |=> flow_out_o == $past(wd[RCGP_B2_FLOWO]))
      else $error("flow control write lost");

   // Reading the first register shows the serial pending bit
   a_rd_pending: assert property (rd_gp1 |=> lb_rdata_o[RCGP_DATA_LSB + RCGP_B1_DBG] == $past(pins_s.serial_pend))
      else $error("serial pending read wrong");

endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps

// Register bank bench: bus answers are queued by the driver and checked by a watcher
module tb_top
import rcgp_pkg::*;
;
   localparam logic [2:0] REV = 3'h5; // Arbitrary revision code
   logic ref_clk_i = 1'b0;
   logic rst_i;
   rcgp_lbreq_type lb_req;
   rcgp_pins_type pins;
   logic [31:0] lb_rdata;
   logic lb_ack;
   rcgp_reqs_type reqs;
   rcgp_ovr_type ovr;
   logic sen_o;
   logic lbus_o;
   logic flow_o;
   logic int_o;
   int num_errors = 0;
   int compares = 0;
   logic [35:0] exp_q[$]; // Expected {reqs, rdata} per access
   logic [7:0] m_ovr; // Model of the writable fields
   logic m_sen;
   logic m_lbus;
   logic m_flow;
   rcgp_pins_type p;
   logic [31:0] w;
   int bits[4] = '{15, 10, 9, 8};

   rcgp_regs #(.REVISION(REV)) i_rcgp_regs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lb_req_i(lb_req),
      .pins_i(pins), .lb_rdata_o(lb_rdata), .lb_ack_o(lb_ack), .reqs_o(reqs), .ovr_o(ovr),
      .serial_int_en_o(sen_o), .local_bus_iface_en_o(lbus_o), .flow_out_o(flow_o), .hw_int17_o(int_o));

   // Free-running 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   // Expected read images, built from the pin levels and the model
   function automatic logic [15:0] img1();
      return {pins.proc_line128, pins.bus_line_size != pins.proc_line128, pins.serial_pend, m_sen, m_lbus,
         pins.proc_ecc, pins.proc_ecc != pins.bus_ecc, pins.soft_cause, m_ovr};
   endfunction

   function automatic logic [15:0] img2();
      return {pins.nproc_m1, pins.nmem, REV, 1'b0, pins.poll_out, pins.io_present, pins.bus_line_size,
         pins.bus_ecc, pins.clk_sel, pins.poll_in, m_flow, pins.flow_in};
   endfunction

   task automatic cmp_ans(input logic [35:0] e, input logic [35:0] g);
      compares++;
      if (e !== g)
      begin
         num_errors++;
         $display("BAD answer exp %h got %h", e, g);
      end
   endtask

   task automatic cmp_lvl(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (e !== g)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // One access per cycle; the request is held until the caller moves on
   task automatic acc(input logic wr, input logic [3:0] fn, input logic [1:0] sz, input logic [15:0] wd);
      logic hit;
      logic [15:0] rd;
      rcgp_reqs_type rq;
      hit = (sz != RCGP_SZ_8) && (fn == RCGP_FN_GP1 || fn == RCGP_FN_GP2);
      rd = 16'h0000;
      rq = '0;
      if (!wr && hit)
         rd = (fn == RCGP_FN_GP1) ? img1() : img2();
      if (wr && hit && fn == RCGP_FN_GP1)
      begin
         rq = {wd[15], wd[10], wd[9], wd[8]};
         m_ovr = wd[7:0];
         m_sen = wd[12];
         m_lbus = wd[11];
      end
      if (wr && hit && fn == RCGP_FN_GP2)
         m_flow = wd[1];
      exp_q.push_back({rq, rd, 16'h0000});
      lb_req = {1'b1, wr, !wr, sz, fn, wd, 16'h0000};
      @(negedge ref_clk_i);
   endtask

   task automatic idle(input int n);
      lb_req = '0;
      repeat (n) @(negedge ref_clk_i);
   endtask

   // Pins pass two sync stages, so let them settle
   task automatic setp(input rcgp_pins_type v);
      pins = v;
      idle(4);
   endtask

   task automatic lv();
      cmp_lvl("ovr", m_ovr, ovr);
      cmp_lvl("sen", {7'h00, m_sen}, {7'h00, sen_o});
      cmp_lvl("lbus", {7'h00, m_lbus}, {7'h00, lbus_o});
      cmp_lvl("flow", {7'h00, m_flow}, {7'h00, flow_o});
   endtask

   task automatic chk_int(input logic e);
      idle(2);
      cmp_lvl("int", {7'h00, e}, {7'h00, int_o});
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watcher: every ack pops one note; outside acks all answer lines must be quiet
   always @(negedge ref_clk_i)
      if (rst_i === 1'b0)
      begin
         if (lb_ack === 1'b1 && exp_q.size() > 0)
            cmp_ans(exp_q.pop_front(), {reqs, lb_rdata});
         else
            cmp_ans(36'h0_0000_0000, {reqs, lb_rdata});
      end

   initial
   begin
      rst_i = 1'b1;
      lb_req = '0;
      pins = '0;
      m_ovr = RCGP_OVR_RST;
      m_sen = 1'b0;
      m_lbus = 1'b0;
      m_flow = 1'b0;
      void'($urandom(32'hF423EEDB));
      // Nine falling edges so that nine rising edges see reset
      repeat (9) @(negedge ref_clk_i);
      rst_i = 1'b0;
      // Reset values
      lv();
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_16, 16'h0000);
      acc(1'b0, RCGP_FN_GP2, RCGP_SZ_32, 16'h0000);
      chk_int(1'b0);
      $display("test reset done");
      // Random pin levels read back through both registers
      repeat (8)
      begin
         p = rcgp_pins_type'(16'($urandom));
         setp(p);
         acc(1'b0, RCGP_FN_GP1, RCGP_SZ_64, 16'h0000);
         acc(1'b0, RCGP_FN_GP2, RCGP_SZ_32, 16'h0000);
      end
      idle(1);
      $display("test status done");
      // Request pulses, back to back, 16, 32 and 64-bit access sizes
      for (int i = 0; i < 4; i++)
         acc(1'b1, RCGP_FN_GP1, 2'(i % 3 + 1), 16'h0001 << bits[i]);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h8700);
      idle(1);
      $display("test requests done");
      // Writable fields versus read-only fields
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'hFFFF);
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      idle(1);
      lv();
      w = $urandom;
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_64, w[15:0]);
      acc(1'b1, RCGP_FN_GP2, RCGP_SZ_16, 16'hFFFF);
      acc(1'b0, RCGP_FN_GP2, RCGP_SZ_16, 16'h0000);
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_16, 16'h0000);
      idle(1);
      lv();
      $display("test fields done");
      // Byte accesses and unmapped functions are answered but change nothing
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_8, 16'h87FF);
      acc(1'b0, RCGP_FN_GP2, RCGP_SZ_8, 16'h0000);
      for (int f = 0; f < 16; f++)
         if (f != 8 && f != 10)
         begin
            acc(1'b1, 4'(f), RCGP_SZ_32, 16'hFFFF);
            acc(1'b0, 4'(f), RCGP_SZ_32, 16'h0000);
         end
      idle(1);
      lv();
      $display("test refused done");
      // Interrupt sources, masking and clearing
      setp('0);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      chk_int(1'b0);
      p = '0;
      p.serial_pend = 1'b1;
      setp(p);
      chk_int(1'b0);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h1000);
      chk_int(1'b1);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      setp('0);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h2000);
      chk_int(1'b1);
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      chk_int(1'b0);
      acc(1'b1, RCGP_FN_GP1, RCGP_SZ_32, 16'h0020);
      chk_int(1'b1);
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      chk_int(1'b0);
      p = '0;
      p.kbd = 1'b1;
      setp(p);
      cmp_lvl("int", 8'h01, {7'h00, int_o});
      acc(1'b0, RCGP_FN_GP1, RCGP_SZ_32, 16'h0000);
      chk_int(1'b0);
      p.bus_ecc = 1'b1;
      setp(p);
      cmp_lvl("int", 8'h01, {7'h00, int_o});
      p.bus_ecc = 1'b0;
      p.bus_line_size = 1'b1;
      setp(p);
      cmp_lvl("int", 8'h01, {7'h00, int_o});
      setp('0);
      cmp_lvl("int", 8'h00, {7'h00, int_o});
      $display("test interrupt done");
      // Every queued answer must have been seen
      for (int k = 0; k < 10 && exp_q.size() > 0; k++)
         @(negedge ref_clk_i);
      cmp_lvl("pending", 8'h00, 8'(exp_q.size()));
      finish_test();
   end
endmodule
